// ---- core/addr_match.sv ----
// Purpose: Station address compare with per-bit mask and broadcast
// Assumes: Broadcast address is OR of address and mask, its zero bits as don't-cares
// Notes:   Purely combinational
`timescale 1ns/100ps

module addr_match (
	input  wire logic [7:0] i_byte,
	input  wire logic [7:0] i_station,
	input  wire logic [7:0] i_mask,
	output logic            o_match
);
	logic given_hit;
	logic bcast_hit;
	logic [7:0] bcast;

	// Masked-off bits are don't-care
	assign given_hit = ((i_byte ^ i_station) & i_mask) == 8'h00;
	assign bcast     = i_station | i_mask;
	assign bcast_hit = ((i_byte ^ 8'hFF) & bcast) == 8'h00;
	assign o_match   = given_hit | bcast_hit;
endmodule : addr_match

// ---- core/baud_gen.sv ----
// Purpose: Derives shift-mode and asynchronous baud enables
// Assumes: Timer overflows arrive as one-cycle pulses
// Notes:   Undoubled timer-1 rate halves the tick stream before the /16
`timescale 1ns/100ps

module baud_gen
	import serial_port_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	input  wire mode_e         i_mode,
	input  wire logic          i_baud_double,
	input  wire logic          i_t2_sel,
	input  wire logic          i_t1_ovf,
	input  wire logic          i_t2_ovf,
	baud_if.gen                baud
);
	logic [3:0] div12_ff;
	logic [3:0] nxt_div12;
	logic       half_ff;
	logic [3:0] sub_cnt_ff;
	logic       m2_half_ff;
	logic       src_tick;
	logic       pre_tick;
	logic       sub_tick_w;

	// Mode 0 divider: one tick per shift clock half period, so a full period is clock / 12
	assign nxt_div12 = (div12_ff == 4'(SHIFT_DIV / 2 - 1)) ? 4'h0 : div12_ff + 4'h1;
	assign baud.shift_tick = (div12_ff == 4'(SHIFT_DIV / 2 - 1));

	// Modes 1 and 3: doubling picks timer 1 / 16 or / 32; timer 2 always / 16
	assign src_tick   = i_t2_sel ? i_t2_ovf : i_t1_ovf;
	assign pre_tick   = src_tick & (i_t2_sel | i_baud_double | half_ff);
	// Mode 2: sub-tick every 2 clocks (doubled) or 4 clocks, giving /32 or /64
	assign sub_tick_w = (i_mode == MODE_FIXED9) ? (m2_half_ff & (i_baud_double | half_ff))
	                                            : pre_tick;
	assign baud.sub_tick = sub_tick_w;
	assign baud.tx_tick  = sub_tick_w & (sub_cnt_ff == 4'(SUBTICKS - 1));

	// Dividers; the fixed-rate toggles reuse half_ff for the extra /2
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div12_ff   <= 4'h0;
			half_ff    <= 1'b0;
			sub_cnt_ff <= 4'h0;
			m2_half_ff <= 1'b0;
		end else begin
			div12_ff   <= nxt_div12;
			m2_half_ff <= ~m2_half_ff;
			if ((i_mode == MODE_FIXED9) ? m2_half_ff : src_tick)
				half_ff <= ~half_ff;
			if (sub_tick_w)
				sub_cnt_ff <= sub_cnt_ff + 4'h1;
		end
	end
endmodule : baud_gen

// ---- core/baud_if.sv ----
// Purpose: Carries baud enables from the rate generator to the shifter logic
// Assumes: One clock domain
// Notes:   All members are one-cycle pulses
`timescale 1ns/100ps

interface baud_if;
	logic shift_tick;   // Mode 0 half-period tick, clock / 6
	logic sub_tick;     // Asynchronous sub-tick, 16 per bit
	logic tx_tick;      // Transmit bit tick, every 16 sub-ticks
	modport gen (output shift_tick, output sub_tick, output tx_tick);
	modport use_ (input shift_tick, input sub_tick, input tx_tick);
endinterface : baud_if

// ---- core/serial_port.sv ----
// Purpose: Four-mode serial port with frame error and address recognition
// Assumes: Inputs synchronous to i_clk; timer overflows are one-cycle pulses
// Notes:   Rx line is assumed glitch-free beyond the mid-bit check
`timescale 1ns/100ps

module serial_port
	import serial_port_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [2:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_t1_ovf,
	input  wire logic        i_t2_ovf,
	input  wire logic        i_rxd_in,
	output logic             o_rxd_out,
	output logic             o_rxd_oe,
	output logic             o_txd
);
	import serial_port_pkg::*;

	typedef enum logic [1:0] {TX_IDLE, TX_ALIGN, TX_SHIFT} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} rx_state_e;

	baud_if baud ();

	// Registers
	logic [7:0] ctrl_ff;
	logic       fe_ff;
	logic [7:0] power_ff;
	logic [7:0] station_ff;
	logic [7:0] mask_ff;
	logic [7:0] rx_byte_ff;
	logic [10:0] tx_sr_ff;
	logic [3:0] tx_cnt_ff;
	tx_state_e  tx_state_ff;
	rx_state_e  rx_state_ff;
	logic [9:0] rx_sr_ff;
	logic [3:0] rx_cnt_ff;
	logic [3:0] rx_sub_ff;
	logic       rxd_prev_ff;
	logic       sclk_ff;

	// Decoded controls
	logic       wr_ctrl;
	logic       wr_buf;
	logic       fe_sel;
	mode_e      mode;
	logic       async_mode;
	logic       nine_bit;
	logic       rx_en;
	logic       filter_en;
	logic       match;
	logic       tx_done_ev;
	logic       rx_done_ev;
	logic       rx_store_ev;
	logic       fe_ev;
	logic       start_edge;
	logic       mid_bit;
	logic       stop_bit;
	logic       ninth_bit;
	logic [7:0] rx_data;
	logic [3:0] last_bit;
	logic       accept;
	logic [7:0] ctrl_read;
	logic [7:0] nxt_rdata;

	assign wr_ctrl    = i_wr & (i_addr == OFS_CTRL);
	assign wr_buf     = i_wr & (i_addr == OFS_BUFFER);
	assign fe_sel     = power_ff[BIT_FE_ACCESS];
	assign mode       = mode_e'(ctrl_ff[BIT_HI_FE:BIT_MODE_LO]);
	assign async_mode = (mode != MODE_SHIFT);
	assign nine_bit   = (mode == MODE_FIXED9) | (mode == MODE_VAR9);
	assign rx_en      = ctrl_ff[BIT_RX_EN];
	assign filter_en  = ctrl_ff[BIT_FILTER] & async_mode;
	assign last_bit   = nine_bit ? 4'(FRAME_BITS_M2) : 4'(FRAME_BITS_M1);

	baud_gen u_baud (
		.i_clk         (i_clk),
		.i_rst_b       (i_rst_b),
		.i_mode        (mode),
		.i_baud_double (power_ff[BIT_BAUD_DBL]),
		.i_t2_sel      (power_ff[BIT_T2_SEL]),
		.i_t1_ovf      (i_t1_ovf),
		.i_t2_ovf      (i_t2_ovf),
		.baud          (baud)
	);

	addr_match u_match (
		.i_byte    (rx_data),
		.i_station (station_ff),
		.i_mask    (mask_ff),
		.o_match   (match)
	);

	// Transmit: frame is shifted LSB first; mode 0 sends only the 8 data bits
	assign tx_done_ev = (tx_state_ff == TX_SHIFT) &
	                    (async_mode ? (baud.tx_tick & (tx_cnt_ff == last_bit))
	                                : (baud.shift_tick & sclk_ff & (tx_cnt_ff == 4'h7)));

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_state_ff <= TX_IDLE;
			tx_sr_ff    <= 11'h7FF;
			tx_cnt_ff   <= 4'h0;
		end else if (wr_buf) begin
			// Async frames wait for the bit tick so the start bit has full length
			tx_state_ff <= async_mode ? TX_ALIGN : TX_SHIFT;
			tx_cnt_ff   <= 4'h0;
			tx_sr_ff    <= async_mode ? {1'b1, nine_bit ? ctrl_ff[BIT_TX_NINTH] : 1'b1, i_wdata, 1'b0}
			                          : {3'h7, i_wdata};
		end else if (tx_state_ff == TX_ALIGN) begin
			if (baud.tx_tick)
				tx_state_ff <= TX_SHIFT;
		end else if (tx_state_ff == TX_SHIFT) begin
			if (tx_done_ev)
				tx_state_ff <= TX_IDLE;
			else if (async_mode ? baud.tx_tick : (baud.shift_tick & sclk_ff)) begin
				tx_sr_ff  <= {1'b1, tx_sr_ff[10:1]};
				tx_cnt_ff <= tx_cnt_ff + 4'h1;
			end
		end
	end

	// Async receiver: 16 sub-ticks per bit, sample at mid-bit
	assign start_edge = rxd_prev_ff & ~i_rxd_in & rx_en;
	assign mid_bit    = baud.sub_tick & (rx_sub_ff == 4'(MID_BIT - 1));
	assign stop_bit   = i_rxd_in;
	assign rx_data    = nine_bit ? rx_sr_ff[8:1] : rx_sr_ff[9:2];
	assign ninth_bit  = rx_sr_ff[9];
	// Frame end at the stop bit's mid-bit sample; shifter already holds data (and ninth) bits
	assign rx_store_ev = async_mode & (rx_state_ff == RX_DATA) & baud.sub_tick &
	                     (rx_sub_ff == 4'(SUBTICKS - 1)) & (rx_cnt_ff == last_bit - 4'h1);
	assign fe_ev       = rx_store_ev & ~stop_bit;
	assign accept      = ~filter_en | (match & (nine_bit ? ninth_bit : stop_bit));
	assign rx_done_ev  = (rx_store_ev & accept & ~ctrl_ff[BIT_RX_DONE]) |
	                     (~async_mode & (rx_state_ff == RX_SYNC) & baud.shift_tick & sclk_ff & (rx_cnt_ff == 4'h7));

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_state_ff <= RX_IDLE;
			rx_sr_ff    <= 10'h000;
			rx_cnt_ff   <= 4'h0;
			rx_sub_ff   <= 4'h0;
			rx_byte_ff  <= RST_BYTE;
			rxd_prev_ff <= 1'b1;
			sclk_ff     <= 1'b1;
		end else begin
			rxd_prev_ff <= i_rxd_in;
			// Shift clock parks low while idle so every transfer begins with a low phase of up to six clocks
			if (~async_mode & (tx_state_ff == TX_IDLE) & (rx_state_ff != RX_SYNC))
				sclk_ff <= 1'b0;
			else if (baud.shift_tick)
				sclk_ff <= ~sclk_ff;
			case (rx_state_ff)
				RX_IDLE: begin
					rx_cnt_ff <= 4'h0;
					rx_sub_ff <= 4'h0;
					if (async_mode & start_edge)
						rx_state_ff <= RX_START;
					else if (~async_mode & rx_en & ~ctrl_ff[BIT_RX_DONE] & tx_state_ff == TX_IDLE)
						rx_state_ff <= RX_SYNC;
				end
				RX_START: if (baud.sub_tick) begin
					rx_sub_ff <= rx_sub_ff + 4'h1;
					if (mid_bit) begin
						rx_sub_ff   <= 4'h0;
						rx_state_ff <= i_rxd_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: if (baud.sub_tick) begin
					rx_sub_ff <= (rx_sub_ff == 4'(SUBTICKS - 1)) ? 4'h0 : rx_sub_ff + 4'h1;
					if (rx_sub_ff == 4'(SUBTICKS - 1)) begin
						rx_sr_ff  <= {i_rxd_in, rx_sr_ff[9:1]};
						rx_cnt_ff <= rx_cnt_ff + 4'h1;
						if (rx_cnt_ff == last_bit - 4'h1)
							rx_state_ff <= RX_IDLE;
					end
				end
				RX_SYNC: if (baud.shift_tick & sclk_ff) begin
					rx_sr_ff  <= {i_rxd_in, rx_sr_ff[9:1]};
					rx_cnt_ff <= rx_cnt_ff + 4'h1;
					if (rx_cnt_ff == 4'h7)
						rx_state_ff <= RX_IDLE;
				end
				default: rx_state_ff <= RX_IDLE;
			endcase
			if (rx_done_ev)
				rx_byte_ff <= async_mode ? rx_data : {i_rxd_in, rx_sr_ff[9:3]};
		end
	end

	// Control register; hardware sets win over software clears
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_ff  <= RST_CTRL;
			fe_ff    <= 1'b0;
			power_ff <= RST_CTRL;
			station_ff <= RST_BYTE;
			mask_ff  <= RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff[BIT_MODE_LO:0] <= i_wdata[BIT_MODE_LO:0];
				if (fe_sel)
					fe_ff <= i_wdata[BIT_HI_FE];
				else
					ctrl_ff[BIT_HI_FE] <= i_wdata[BIT_HI_FE];
			end
			if (i_wr & (i_addr == OFS_POWER))
				power_ff <= i_wdata;
			if (i_wr & (i_addr == OFS_STATION))
				station_ff <= i_wdata;
			if (i_wr & (i_addr == OFS_MASK))
				mask_ff <= i_wdata;
			if (fe_ev)
				fe_ff <= 1'b1;
			if (tx_done_ev)
				ctrl_ff[BIT_TX_DONE] <= 1'b1;
			if (rx_done_ev) begin
				ctrl_ff[BIT_RX_DONE] <= 1'b1;
				if (async_mode)
					ctrl_ff[BIT_RX_NINTH] <= nine_bit ? ninth_bit : stop_bit;
			end
		end
	end

	// Read mux, answer one cycle later
	assign ctrl_read = {fe_sel ? fe_ff : ctrl_ff[BIT_HI_FE], ctrl_ff[BIT_MODE_LO:0]};
	assign nxt_rdata = !i_rd ? 8'h00 :
	                   (i_addr == OFS_CTRL)    ? ctrl_read :
	                   (i_addr == OFS_BUFFER)  ? rx_byte_ff :
	                   (i_addr == OFS_STATION) ? station_ff :
	                   (i_addr == OFS_MASK)    ? mask_ff :
	                   (i_addr == OFS_POWER)   ? power_ff : 8'h00;

	// Pins: mode 0 drives data on the rx pin and shift clock on tx pin
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata   <= 8'h00;
			o_txd     <= 1'b1;
			o_rxd_out <= 1'b1;
			o_rxd_oe  <= 1'b0;
		end else begin
			o_rdata   <= nxt_rdata;
			o_rxd_oe  <= ~async_mode & (tx_state_ff == TX_SHIFT);
			o_rxd_out <= tx_sr_ff[0];
			o_txd     <= async_mode ? ((tx_state_ff == TX_SHIFT) ? tx_sr_ff[0] : 1'b1)
			                        : ((tx_state_ff == TX_SHIFT || rx_state_ff == RX_SYNC) ? sclk_ff : 1'b1);
		end
	end

	a_tx_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		tx_done_ev |=> ctrl_ff[BIT_TX_DONE]) else $error("tx done flag not set");
	a_fe_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fe_ff & ~wr_ctrl |=> fe_ff) else $error("frame error cleared without write");
	a_fe_on_bad_stop: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fe_ev |=> fe_ff) else $error("frame error not flagged");
	a_filter_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		rx_store_ev & filter_en & ~match |-> ~rx_done_ev) else $error("filtered byte accepted");
	a_rx_enable_block: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		rx_state_ff == RX_IDLE & ~rx_en |=> rx_state_ff == RX_IDLE) else $error("rx began while disabled");
	a_write_starts_tx: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		wr_buf |=> tx_state_ff != TX_IDLE) else $error("write did not start tx");
	a_mode0_no_filter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		mode == MODE_SHIFT |-> ~filter_en) else $error("filter active in mode 0");
	a_read_ctrl_bit7: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_rd & i_addr == OFS_CTRL & fe_sel |=> o_rdata[BIT_HI_FE] == $past(fe_ff)) else $error("bit 7 wrong");
	c_tx_done: cover property (@(posedge i_clk) disable iff (!i_rst_b) tx_done_ev);
	c_rx_done: cover property (@(posedge i_clk) disable iff (!i_rst_b) rx_done_ev & async_mode);
	c_frame_err: cover property (@(posedge i_clk) disable iff (!i_rst_b) fe_ev);
endmodule : serial_port

// ---- core/serial_port_pkg.sv ----
// Purpose: Shared constants for the multimode serial port with address filter
// Assumes: 10 MHz system clock, register port with one-cycle read latency
// Notes:   Register offsets are local choices; timing counts derive from the clock

package serial_port_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned ADDR_W        = 3;
	// Register offsets
	localparam logic [2:0]  OFS_CTRL      = 3'h0;
	localparam logic [2:0]  OFS_BUFFER    = 3'h1;
	localparam logic [2:0]  OFS_STATION   = 3'h2;
	localparam logic [2:0]  OFS_MASK      = 3'h3;
	localparam logic [2:0]  OFS_POWER     = 3'h4;
	// serial_ctrl field positions
	localparam int unsigned BIT_HI_FE     = 7;
	localparam int unsigned BIT_MODE_LO   = 6;
	localparam int unsigned BIT_FILTER    = 5;
	localparam int unsigned BIT_RX_EN     = 4;
	localparam int unsigned BIT_TX_NINTH  = 3;
	localparam int unsigned BIT_RX_NINTH  = 2;
	localparam int unsigned BIT_TX_DONE   = 1;
	localparam int unsigned BIT_RX_DONE   = 0;
	// power_control field positions
	localparam int unsigned BIT_BAUD_DBL  = 7;
	localparam int unsigned BIT_FE_ACCESS = 6;
	localparam int unsigned BIT_T2_SEL    = 0;
	// Reset values
	localparam logic [7:0]  RST_CTRL      = 8'h00;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	// Timing
	localparam int unsigned SHIFT_DIV     = 12;   // Mode 0 bit rate is clock / 12
	localparam int unsigned MODE2_DIV     = 2;    // Mode 2 sub-tick: clock/2 gives clock/32 per bit
	localparam int unsigned SUBTICKS      = 16;   // Sub-ticks per asynchronous bit
	localparam int unsigned MID_BIT       = 8;    // Sub-tick index at mid-bit
	localparam int unsigned FRAME_BITS_M1 = 9;    // 8 data + stop, counted after the start bit
	localparam int unsigned FRAME_BITS_M2 = 10;   // 8 data + ninth + stop, counted after the start bit

	typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC8, MODE_FIXED9, MODE_VAR9} mode_e;
endpackage : serial_port_pkg

// ---- testbench/multimode_serial_port_addr_filter_tb.sv ----
// Purpose: Self-checking bench for the multimode serial port
// Assumes: Timer overflows every second clock, so async bits last 32 clocks
// Notes:   Flags are polled over the register port with a bounded count
`timescale 1ns/100ps

module multimode_serial_port_addr_filter_tb;
	import serial_port_pkg::*;
	logic       i_clk     = 1'b0;
	logic       i_rst_b   = 1'b0;
	logic [2:0] i_addr    = 3'h0;
	logic [7:0] i_wdata   = 8'h00;
	logic       i_wr      = 1'b0;
	logic       i_rd      = 1'b0;
	logic       i_t1_ovf  = 1'b0;
	logic       i_t2_ovf  = 1'b1;
	logic [7:0] o_rdata;
	logic       o_rxd_out;
	logic       o_rxd_oe;
	logic       o_txd;
	logic       line;
	int         n_errors        = 0;
	int         samples_checked = 0;

	always #50 i_clk = ~i_clk;
	// Free-running overflow pulses; both timers feed the rate generator
	always @(posedge i_clk) begin
		i_t1_ovf <= ~i_t1_ovf;
		i_t2_ovf <= ~i_t2_ovf;
	end

	serial_port dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_t1_ovf(i_t1_ovf), .i_t2_ovf(i_t2_ovf), .i_rxd_in(line),
		.o_rxd_out(o_rxd_out), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd));
	uart_peer peer (.i_clk(i_clk), .i_txd(o_txd), .i_rxd_out(o_rxd_out), .i_rxd_oe(o_rxd_oe), .o_line(line));

	task summarize;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask : rd

	task wait_bit(input int b);
		logic [7:0] v;
		v = '0;
		for (int i = 0; i < 500 && v[b] !== 1'b1; i++) rd(OFS_CTRL, v);
		chk({7'h00, v[b]}, 8'h01);
	endtask : wait_bit

	// Frame idles long enough after the stop bit for any flag to land
	task rx_quiet(input logic [7:0] d, input logic n9, input int n);
		logic [7:0] v;
		peer.send({1'b1, n9, d, 1'b0}, n);
		repeat (40) @(posedge i_clk);
		rd(OFS_CTRL, v);
		chk(v & 8'h01, 8'h00);
	endtask : rx_quiet

	task t_regs;
		logic [7:0] v;
		rd(OFS_CTRL, v); chk(v, RST_CTRL);
		rd(OFS_BUFFER, v); chk(v, RST_BYTE);
		wr(OFS_STATION, 8'h5A); wr(OFS_MASK, 8'hA5); wr(3'h7, 8'hFF);
		rd(OFS_STATION, v); chk(v, 8'h5A);
		rd(OFS_MASK, v); chk(v, 8'hA5);
		rd(3'h7, v); chk(v, 8'h00);
	endtask : t_regs

	task t_mode2_tx;
		logic [10:0] f;
		wr(OFS_POWER, 8'h80); wr(OFS_CTRL, 8'h88);
		fork
			peer.recv(11, f);
			wr(OFS_BUFFER, 8'hA5);
		join
		chk(f[8:1], 8'hA5);
		chk({5'h00, f[10:9], f[0]}, 8'h06);
		wait_bit(1);
	endtask : t_mode2_tx

	// Compare pattern 110000x0: C2 matches, C4 differs in a compared bit
	task t_mode3_filter;
		logic [7:0] v;
		wr(OFS_STATION, 8'hC0); wr(OFS_MASK, 8'hFD); wr(OFS_CTRL, 8'hF0);
		peer.send({1'b1, 1'b1, 8'hC2, 1'b0}, 11);
		wait_bit(0);
		rd(OFS_BUFFER, v); chk(v, 8'hC2);
		rd(OFS_CTRL, v); chk(v & 8'h04, 8'h04);
		wr(OFS_CTRL, 8'hF0);
		rx_quiet(8'hC4, 1'b1, 11);
		rx_quiet(8'hC2, 1'b0, 11);
	endtask : t_mode3_filter

	task t_mode1_fe;
		logic [7:0] v;
		wr(OFS_POWER, 8'h01); wr(OFS_CTRL, 8'h50);
		peer.send({1'b1, 1'b0, 8'h33, 1'b0}, 10);
		repeat (40) @(posedge i_clk);
		rd(OFS_CTRL, v); chk(v & 8'h80, 8'h00);
		wr(OFS_POWER, 8'h41);
		rd(OFS_CTRL, v); chk(v & 8'h80, 8'h80);
		wr(OFS_CTRL, 8'hD0);
		peer.send({1'b1, 1'b1, 8'h66, 1'b0}, 10);
		wait_bit(0);
		rd(OFS_CTRL, v); chk(v & 8'h84, 8'h84);
		wr(OFS_CTRL, 8'h50);
		rd(OFS_CTRL, v); chk(v & 8'h80, 8'h00);
		wr(OFS_CTRL, 8'h40);
		rx_quiet(8'h66, 1'b1, 10);
		wr(OFS_CTRL, 8'h70);
		rx_quiet(8'hC4, 1'b1, 10);
		peer.send({1'b1, 1'b1, 8'hC2, 1'b0}, 10);
		wait_bit(0);
	endtask : t_mode1_fe

	// Filter bit set in mode 0 is ignored for a byte that would fail the compare
	task t_mode0;
		logic [7:0] v;
		int         per;
		wr(OFS_POWER, 8'h00); wr(OFS_CTRL, 8'h00);
		fork
			peer.shift_out(v, per);
			wr(OFS_BUFFER, 8'h3C);
		join
		chk(v, 8'h3C);
		chk(per[7:0], 8'h0C);
		wait_bit(1);
		fork
			peer.shift_in(8'h96);
			wr(OFS_CTRL, 8'h30);
		join
		wait_bit(0);
		rd(OFS_BUFFER, v); chk(v, 8'h96);
	endtask : t_mode0

	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_regs();
		t_mode2_tx();
		t_mode3_filter();
		t_mode1_fe();
		t_mode0();
		summarize();
	end

	// Whole run needs under a millisecond; three is ample slack
	initial begin
		#3_000_000;
		n_errors++;
		summarize();
	end
endmodule : multimode_serial_port_addr_filter_tb

// ---- testbench/uart_peer.sv ----
// Purpose: Remote serial peer on the far side of the serial port pins
// Assumes: 32 clocks per asynchronous bit; the receive line is pulled up
// Notes:   Mode 0 data is held across each shift clock rise
`timescale 1ns/100ps

module uart_peer (
	input  wire logic i_clk,
	input  wire logic i_txd,
	input  wire logic i_rxd_out,
	input  wire logic i_rxd_oe,
	output logic      o_line
);
	logic drv = 1'b1;
	// Device drive wins; released line returns to the pull-up level
	assign o_line = i_rxd_oe ? i_rxd_out : drv;

	// Frame goes out LSB first with the start bit in f[0]
	task send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk) drv <= f[i];
			repeat (31) @(posedge i_clk);
		end
		@(posedge i_clk) drv <= 1'b1;
	endtask : send

	// Mid-bit sampling keeps clear of edge jitter on the line
	task recv(input int n, output logic [10:0] f);
		f = '0;
		@(negedge i_txd);
		repeat (16) @(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			f[i] = i_txd;
			repeat (32) @(posedge i_clk);
		end
	endtask : recv

	// Present each bit before the device's shift clock rises
	task shift_in(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			drv <= d[i];
			@(posedge i_txd);
			if (i < 7) @(negedge i_txd);
		end
		// Hold the last bit past the device's sampling edge
		repeat (8) @(posedge i_clk);
		drv <= 1'b1;
	endtask : shift_in

	// Capture device shift data and the shift clock period in clocks
	task shift_out(output logic [7:0] d, output int per);
		time t0;
		d = '0;
		t0 = 0;
		per = 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge i_txd);
			per = int'(($time - t0) / 100);
			t0 = $time;
			@(negedge i_clk) d[i] = i_rxd_out;
		end
	endtask : shift_out
endmodule : uart_peer
